// ---- hw/ext_write_pkg.sv ----
// constants and types shared by the external memory write master
package ext_write_pkg;
    localparam int addr_width_default = 32; // address bus width
    localparam int data_width_default = 32; // data bus width
    localparam int wait_width_default = 5; // width of the wait-state count
    localparam int clk_period_ns = 10; // ref_clk period
    localparam int hold_time_ns = 10; // one address-hold period
    localparam int idle_time_ns = 10; // one bus-idle period
    localparam int hold_cycles = (hold_time_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int idle_cycles = (idle_time_ns + clk_period_ns - 1) / clk_period_ns;
    localparam logic strobe_off = 1'h1; // strobes are active low
    localparam logic strobe_on = 1'h0;
    localparam logic [1:0] ack_settle = 2'h3; // first strobe cycle plus the two synchroniser stages
    typedef enum logic [2:0] {st_idle, st_setup, st_strobe, st_hold, st_gap} phase_type;
endpackage

// ---- hw/external_memory_write_master.sv ----
// external memory bus master: asynchronous strobed write and read accesses
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - acknowledge is looked at only once the programmed wait states of the access are counted out.
// - each programmed wait state lengthens the strobe low time by one clock period.
// - with address hold on, address and write data stay driven one period after the strobe rises.
// - with bus idle on and address hold off, one extra period passes between releasing the data bus and the next strobe.
// - after a write strobe the next strobe waits one more period if address hold or bus idle is on.
// - the output clock toggles only while an access is in progress and is parked low otherwise.
// - on a broadcast write the master drives acknowledge high for one cycle then releases it.
// - every address, select, burst and strobe transition is launched from a ref_clk edge.
module external_memory_write_master #(
    parameter int addr_width = ext_write_pkg::addr_width_default,
    parameter int data_width = ext_write_pkg::data_width_default,
    parameter int wait_width = ext_write_pkg::wait_width_default
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic req_valid, // access request
    output logic req_ready, // high when a request is taken
    input wire logic req_write, // 1 write, 0 read
    input wire logic req_broadcast, // broadcast write, precharge acknowledge
    input wire logic req_burst, // access is part of a burst
    input wire logic [addr_width-1:0] req_addr, // access address
    input wire logic [data_width-1:0] req_wdata, // write data
    input wire logic [wait_width-1:0] wait_states, // programmed wait states
    input wire logic addr_hold_en, // add an address-hold cycle
    input wire logic bus_idle_en, // add a bus-idle cycle
    output logic done, // one-cycle pulse at access end
    output logic [data_width-1:0] rdata, // read data, valid with done
    output logic [addr_width-1:0] addr_out, // address pins
    output logic memory_select_n, // memory select, active low
    output logic write_strobe_n, // write strobe, active low
    output logic read_strobe_n, // read strobe, active low
    output logic burst_indicator, // burst pin
    output logic [data_width-1:0] data_out, // data pins, driven value
    output logic data_oe, // data pins driven
    input wire logic [data_width-1:0] data_in, // data pins, sampled value
    input wire logic ack_in, // acknowledge pin, sampled value
    output logic ack_out, // acknowledge precharge value
    output logic ack_oe, // acknowledge pin driven
    output logic output_clock, // gated output clock
    output logic output_clock_oe // output clock driven
);
    import ext_write_pkg::*;

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    if (addr_width < 1 || data_width < 1 || wait_width < 1 || wait_width > 16)
    begin : g_width_check
        $error("external_memory_write_master: unsupported width");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        phase_type phase;
        logic [wait_width-1:0] cnt;
        logic [addr_width-1:0] addr;
        logic [data_width-1:0] wdata;
        logic [data_width-1:0] rdata;
        logic write;
        logic bcast;
        logic burst;
        logic hold;
        logic idle;
        logic [1:0] settle; // cycles left before acknowledge may end the strobe
        logic sel_n;
        logic wr_n;
        logic rd_n;
        logic doe;
        logic aout;
        logic aoe;
        logic oclk;
        logic done;
        logic ack_meta;
        logic ack_sync;
    } state_type;

    state_type s_q;
    state_type s_d;

    // next-state logic
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'h0;
        s_d.aoe = 1'h0;
        s_d.aout = 1'h0;
        s_d.ack_meta = ack_in;
        s_d.ack_sync = s_q.ack_meta; // two-flop synchroniser
        s_d.oclk = (s_q.phase != st_idle) ? ~s_q.oclk : 1'h0;
        case (s_q.phase)
            st_idle:
            begin
                if (req_valid)
                begin
                    s_d.phase = st_setup;
                    s_d.addr = req_addr;
                    s_d.wdata = req_wdata;
                    s_d.write = req_write;
                    s_d.bcast = req_broadcast & req_write;
                    s_d.burst = req_burst;
                    s_d.hold = addr_hold_en;
                    s_d.idle = bus_idle_en;
                    s_d.cnt = wait_states;
                    s_d.sel_n = strobe_on;
                    s_d.doe = req_write;
                end
            end
            st_setup:
            begin
                s_d.phase = st_strobe;
                s_d.settle = ack_settle;
                s_d.wr_n = s_q.write ? strobe_on : strobe_off;
                s_d.rd_n = s_q.write ? strobe_off : strobe_on;
                s_d.aoe = s_q.bcast;
                s_d.aout = s_q.bcast;
            end
            st_strobe:
            begin
                if (s_q.cnt != '0)
                begin
                    s_d.cnt = s_q.cnt - 1'h1;
                    s_d.settle = ack_settle; // acknowledge counts only once sampled after the waits
                end
                else if (s_q.settle != '0)
                    s_d.settle = s_q.settle - 1'h1; // first cycle and synchroniser flush
                else if (s_q.ack_sync)
                begin
                    s_d.wr_n = strobe_off;
                    s_d.rd_n = strobe_off;
                    s_d.rdata = data_in;
                    if (s_q.hold)
                        s_d.phase = st_hold;
                    else
                    begin
                        s_d.phase = st_gap; // select stays low across the strobe rise
                        s_d.doe = 1'h0;
                    end
                end
            end
            st_hold:
            begin
                s_d.phase = st_gap; // address and data kept this period
                s_d.doe = 1'h0;
                s_d.sel_n = strobe_off;
                s_d.idle = 1'h0; // hold and idle together cost one period only
            end
            st_gap:
            begin
                s_d.sel_n = strobe_off;
                if (s_q.idle)
                    s_d.idle = 1'h0; // bus released, no strobe this period
                else
                begin
                    s_d.phase = st_idle;
                    s_d.done = 1'h1;
                end
            end
            default:
            begin
                s_d.phase = st_idle;
            end
        endcase
        if (rst)
            s_d = '{phase: st_idle, sel_n: strobe_off, wr_n: strobe_off, rd_n: strobe_off, default: '0};
    end

    // state register
    always_ff @(posedge ref_clk)
    begin
        s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign req_ready = (s_q.phase == st_idle) && !rst;
    assign done = s_q.done;
    assign rdata = s_q.rdata;
    assign addr_out = s_q.addr;
    assign memory_select_n = s_q.sel_n;
    assign write_strobe_n = s_q.wr_n;
    assign read_strobe_n = s_q.rd_n;
    assign burst_indicator = s_q.burst & (s_q.phase != st_idle);
    assign data_out = s_q.wdata;
    assign data_oe = s_q.doe;
    assign ack_out = s_q.aout;
    assign ack_oe = s_q.aoe;
    assign output_clock = s_q.oclk;
    assign output_clock_oe = (s_q.phase != st_idle) || s_q.done;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_STROBE_WAITS: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4])
        else $error("write strobe shorter than wait states allow");
    AST_ACK_IGNORED: assert property (s_q.phase == st_strobe && s_q.cnt != '0 |=> s_q.phase == st_strobe)
        else $error("access ended before wait states counted");
    AST_SEL_BEFORE_STROBE: assert property ($fell(write_strobe_n) |-> !memory_select_n && !$past(memory_select_n))
        else $error("select not set up before write strobe");
    AST_SEL_AFTER_STROBE: assert property ($rose(write_strobe_n) |-> !memory_select_n)
        else $error("select dropped with write strobe");
    AST_ADDR_HOLD: assert property ($rose(write_strobe_n) && s_q.hold |-> data_oe ##1 !data_oe)
        else $error("address hold period missing");
    AST_IDLE_GAP: assert property ($rose(write_strobe_n) && s_q.idle && !s_q.hold |-> !data_oe && write_strobe_n [*2])
        else $error("bus idle period missing");
    AST_NEXT_DELAY: assert property ($rose(write_strobe_n) && (s_q.hold || s_q.idle) |-> write_strobe_n [*4])
        else $error("next strobe too early");
    AST_CLOCK_GATED: assert property (s_q.phase == st_idle && !s_q.done |=> !output_clock)
        else $error("output clock running while idle");
    AST_PRECHARGE: assert property (ack_oe |=> !ack_oe)
        else $error("acknowledge precharge longer than one cycle");
    AST_PRECHARGE_WHEN: assert property ($fell(write_strobe_n) && s_q.bcast |-> ack_oe && ack_out)
        else $error("broadcast write without precharge");
    AST_DONE_STROBE: assert property (done |-> write_strobe_n && read_strobe_n)
        else $error("done while strobe active");

    COV_WRITE: cover property ($fell(write_strobe_n) ##[1:40] done);
    COV_READ: cover property ($fell(read_strobe_n) ##[1:40] done);
    COV_HOLD: cover property (s_q.phase == st_hold);
    COV_GAP: cover property (s_q.phase == st_gap);
endmodule
`default_nettype wire

// ---- verification/ext_mem_model.sv ----
// behavioural external memory that answers the write master
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
    input wire logic ref_clk, // system clock
    input wire logic rst, // sync reset
    input wire logic memory_select_n, // select from master
    input wire logic write_strobe_n, // write strobe
    input wire logic read_strobe_n, // read strobe
    input wire logic [31:0] data_out, // master data
    input wire logic [3:0] ack_delay, // cycles before ack rises
    output logic ack_in, // acknowledge to master
    output logic [31:0] data_in // read data
);
    logic [31:0] mem_q;
    logic [3:0] cnt_q;
    // ack low in the first cycle, later moved on clock edges only
    always_ff @(posedge ref_clk)
    begin
        cnt_q <= (rst || memory_select_n) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
        ack_in <= !rst && !memory_select_n && cnt_q >= ack_delay;
        if (!write_strobe_n)
            mem_q <= data_out;
    end
    // a released bus shows the inverse, never the stored word
    assign data_in = read_strobe_n ? ~mem_q : mem_q;
endmodule
`default_nettype wire

// ---- verification/tb_external_memory_write_master.sv ----
// self-checking bench for the external memory write master
`timescale 1ns/1ns
`default_nettype none
module tb_external_memory_write_master;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0, req_write = 1'b1, req_broadcast = 1'b0, req_burst = 1'b0;
    logic addr_hold_en = 1'b0, bus_idle_en = 1'b0;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0;
    logic [4:0] wait_states = 5'h0;
    logic [3:0] ack_delay = 4'h1;
    logic req_ready, done, memory_select_n, write_strobe_n, read_strobe_n, burst_indicator;
    logic data_oe, ack_in, ack_out, ack_oe, output_clock, output_clock_oe, hsel, hdoe;
    logic burst_next = 1'b0;
    logic [31:0] rdata, addr_out, data_out, data_in;
    int num_errors = 0, n_checks = 0, cyc = 0, len, gap, rise, ackc, bad, togs, len0, gap0;
    external_memory_write_master i_external_memory_write_master (.ref_clk, .rst, .req_valid,
        .req_ready, .req_write, .req_broadcast, .req_burst, .req_addr, .req_wdata, .wait_states,
        .addr_hold_en, .bus_idle_en, .done, .rdata, .addr_out, .memory_select_n, .write_strobe_n,
        .read_strobe_n, .burst_indicator, .data_out, .data_oe, .data_in, .ack_in, .ack_out,
        .ack_oe, .output_clock, .output_clock_oe);
    ext_mem_model i_ext_mem_model (.ref_clk, .rst, .memory_select_n, .write_strobe_n,
        .read_strobe_n, .data_out, .ack_delay, .ack_in, .data_in);
    // ---------------------------------------------------------------
    // clock, timeout and reporting
    // ---------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one access; measures strobe length, gap, precharge and pin order
    task automatic access(input logic wr, bc, hd, id, input logic [4:0] w, input logic [31:0] a);
        logic ok, pn, ps, pc, s;
        @(posedge ref_clk);
        {req_write, req_broadcast, addr_hold_en, bus_idle_en} <= {wr, bc, hd, id};
        {wait_states, req_addr, req_wdata, req_valid} <= {w, a, ~a, 1'b1};
        req_burst <= burst_next;
        do
        begin
            @(negedge ref_clk);
            ok = req_ready;
            @(posedge ref_clk);
        end while (ok !== 1'b1);
        req_valid <= 1'b0;
        {len, ackc, bad, togs, pn, ps, pc} = {128'h0, 1'b1, 1'b1, output_clock};
        repeat (60)
        begin
            @(negedge ref_clk);
            s = write_strobe_n & read_strobe_n;
            if (s === 1'b0)
            begin
                len++;
                if (pn)
                    gap = cyc - rise;
                if (memory_select_n !== 1'b0 || addr_out !== a || (pn && ps !== 1'b0) || burst_indicator !== burst_next)
                    bad++;
                if (wr && (data_out !== ~a || data_oe !== 1'b1))
                    bad++;
            end
            else if (!pn)
                {rise, hsel, hdoe} = {cyc, memory_select_n, data_oe};
            ackc += (ack_oe === 1'b1 && ack_out === 1'b1);
            togs += (output_clock !== pc);
            {pn, ps, pc} = {s, memory_select_n, output_clock};
            if (done === 1'b1)
                break;
        end
        check("access_done", 1, done);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_wait_states();
        access(1, 0, 0, 0, 0, 32'h1);
        len0 = len;
        access(1, 0, 0, 0, 3, 32'h2);
        check("strobe_len", len0 + 3, len);
        check("pin_order", 0, bad);
        check("busy_clock", 1, togs > 0);
        check("rise_select", 0, hsel);
        check("plain_data", 0, hdoe);
    endtask
    task automatic t_hold_idle();
        access(1, 0, 0, 0, 0, 32'h10);
        access(1, 0, 0, 0, 0, 32'h11);
        gap0 = gap;
        access(1, 0, 1, 0, 0, 32'h12);
        access(1, 0, 1, 0, 0, 32'h13);
        check("hold_gap", gap0 + 1, gap);
        check("hold_select", 0, hsel);
        check("hold_order", 0, bad);
        check("hold_data", 1, hdoe);
        access(1, 0, 0, 1, 0, 32'h14);
        access(1, 0, 0, 1, 0, 32'h15);
        check("idle_gap", gap0 + 1, gap);
        check("idle_data", 0, hdoe);
        check("idle_select", 0, hsel);
    endtask
    task automatic t_broadcast_read();
        burst_next = 1'b1;
        access(1, 1, 0, 0, 0, 32'h30);
        burst_next = 1'b0;
        check("precharge_cycles", 1, ackc);
        check("burst_order", 0, bad);
        access(1, 0, 0, 0, 2, 32'h40);
        check("no_precharge", 0, ackc);
        access(0, 0, 0, 0, 2, 32'h40);
        check("read_data", ~32'h40, rdata);
        check("read_order", 0, bad);
    endtask
    task automatic t_idle_clock();
        togs = 0;
        repeat (8)
        begin
            @(negedge ref_clk);
            togs += (output_clock_oe !== 1'b0 || output_clock !== 1'b0);
        end
        check("idle_clock", 0, togs);
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_wait_states();
        t_hold_idle();
        t_broadcast_read();
        t_idle_clock();
        finish_test();
    end
endmodule
`default_nettype wire
